// ==== css_socket_regs.sv ====
// css_socket_regs.sv: socket state word, force word and event flags of one card socket
//
// Function
// [R1] alternative socket voltage bits read zero
// [R2] low-volt socket bit one unless overridden
// [R3] high-volt socket bit always one
// [R4] state bits 27..14 read zero
// [R5] card voltage bits, also set by force
// [R6] invalid power request flag, reset zero
// [R7] removal data loss flag, reset zero
// [R8] unrecognized card flag held until valid card
// [R9] ready pin live level in bit 6
// [R10] card type bits change only on interrogation; force writes also load them
// [R11] powered bit, reset zero
// [R12] detect pins mirrored, frozen during interrogation
// [R13] status pin live level in bit 0
// [R14] force reserved bits read zero
// [R15] force bit 14 reinterrogates, re-enables power
// [R16] force voltage bits load, disable power control
// [R17] force bits load state flags
// [R18] force bit 3 sets power event
// [R19] force bits 2,1 set detect events
// [R20] force bit 0 sets status event
// [R21] software uses bit 14 for interrogation
// [R22] force word at offset 0x0c
// [R23] state word at 0x08, reset 3000_000x
// [R24] event flags set on change, W1C
// [R25] status event: narrow both edges, wide rising
// [R26] force one sets event, reads zero
// [R27] power control off until bit 14
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`include "css_cfg.svh"
module css_socket_regs #(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // card pins
    input wire logic card_ready_irq_pin,
    input wire logic detect_pin_a,
    input wire logic detect_pin_b,
    input wire logic status_pin,
    // device-wide control
    input wire logic low_volt_override,
    // interrogation sequencer
    input wire logic interrog_busy,
    input wire logic interrog_done,
    input wire logic [3:0] interrog_card_volt,
    input wire logic interrog_wide,
    input wire logic interrog_narrow,
    input wire logic interrog_unrecog,
    output logic reinterrogate_req,
    // power path
    input wire logic socket_power_good,
    input wire logic invalid_request_set,
    input wire logic removal_loss_set,
    output logic power_ctrl_enable,
    // event flags for the mask logic
    output logic [3:0] socket_events
);
    import css_pkg::*;

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    generate
        if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr
            $error("css_socket_regs: ADDR_W must be 4 to 8");
        end
    endgenerate

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic css_sel_t decode(input logic [ADDR_W-1:0] a);
        logic [7:0] off;
        off = 8'(a);
        case (off)
            `CSS_OFF_EVENT: decode = CSS_SEL_EVENT;
            // [R23] state word offset
            `CSS_OFF_STATE: decode = CSS_SEL_STATE;
            // [R22] force word offset
            `CSS_OFF_FORCE: decode = CSS_SEL_FORCE;
            default: decode = CSS_SEL_NONE;
        endcase
    endfunction : decode

    // ----------------------------------------
    // state and links
    // ----------------------------------------
    css_core_t s;
    css_core_t next_s;
    css_sel_t wr_sel;
    css_sel_t rd_sel;
    logic [31:0] state_word;
    logic force_wr;

    css_evt_if ev ();

    css_event_unit u_events (
        .clk(clk),
        .reset_n(reset_n),
        .ev(ev)
    );

    assign wr_sel = decode(reg_addr);
    assign rd_sel = decode(reg_addr);
    assign force_wr = reg_write && (wr_sel == CSS_SEL_FORCE);

    // ----------------------------------------
    // state word assembly
    // ----------------------------------------
    always_comb begin
        // [R4] reserved bits zero
        state_word = 32'h0000_0000;
        // [R1] alternative voltages unsupported
        state_word[`CSS_ST_ALT_B_SOCK] = 1'b0;
        state_word[`CSS_ST_ALT_A_SOCK] = 1'b0;
        // [R2] low-volt capability override
        state_word[`CSS_ST_LOW_SOCK] = ~low_volt_override;
        // [R3] high-volt always supplied
        state_word[`CSS_ST_HIGH_SOCK] = 1'b1;
        // [R5] card voltage support
        state_word[`CSS_ST_VOLT_HI:`CSS_ST_VOLT_LO] = s.card_volt;
        state_word[`CSS_ST_INVALID] = s.invalid_req;
        state_word[`CSS_ST_LOSS] = s.removal_loss;
        state_word[`CSS_ST_UNRECOG] = s.unrecog;
        // [R9] ready pin live
        state_word[`CSS_ST_READY] = card_ready_irq_pin;
        state_word[`CSS_ST_WIDE] = s.wide;
        state_word[`CSS_ST_NARROW] = s.narrow;
        state_word[`CSS_ST_POWERED] = s.powered;
        state_word[`CSS_ST_DET_B] = s.det_b;
        state_word[`CSS_ST_DET_A] = s.det_a;
        // [R13] status pin live
        state_word[`CSS_ST_STATUS] = status_pin;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.reinterrog = 1'b0;
        ev.force_set = 4'h0;
        ev.clear = 4'h0;

        // software force loads first, so hardware events of the same cycle win
        if (force_wr) begin
            // [R16] forced voltage bits
            next_s.card_volt = reg_wdata[`CSS_FO_VOLT_HI:`CSS_FO_VOLT_LO];
            // [R27] power control stays off
            if (|reg_wdata[`CSS_FO_VOLT_HI:`CSS_FO_VOLT_LO]) begin
                next_s.power_ctrl_en = 1'b0;
            end
            // [R17] forced state flags
            next_s.invalid_req = reg_wdata[`CSS_FO_INVALID];
            next_s.removal_loss = reg_wdata[`CSS_FO_LOSS];
            next_s.unrecog = reg_wdata[`CSS_FO_UNRECOG];
            next_s.wide = reg_wdata[`CSS_FO_WIDE];
            next_s.narrow = reg_wdata[`CSS_FO_NARROW];
            // [R18] [R19] [R20] [R26] event forcing, levels untouched
            ev.force_set = reg_wdata[`CSS_FO_EVT_HI:`CSS_FO_EVT_LO];
            // [R15] [R21] reinterrogation request
            if (reg_wdata[`CSS_FO_REINTERROG]) begin
                next_s.reinterrog = 1'b1;
                next_s.power_ctrl_en = 1'b1;
            end
        end

        // [R24] write one clears events
        if (reg_write && (wr_sel == CSS_SEL_EVENT)) begin
            ev.clear = reg_wdata[`CSS_EVT_W-1:0];
        end

        // [R10] card type from interrogation, also loaded by force writes
        if (interrog_done) begin
            next_s.card_volt = interrog_card_volt;
            next_s.wide = interrog_wide;
            next_s.narrow = interrog_narrow;
            // [R8] cleared by a valid card, or by a force write with bit 7 zero
            next_s.unrecog = interrog_unrecog;
        end

        // [R6] invalid request flag
        if (invalid_request_set) begin
            next_s.invalid_req = 1'b1;
        end
        // [R7] removal data loss flag
        if (removal_loss_set) begin
            next_s.removal_loss = 1'b1;
        end

        // [R11] powered result
        next_s.powered = socket_power_good;

        // [R12] detect mirror, frozen while interrogating
        if (!interrog_busy) begin
            next_s.det_a = detect_pin_a;
            next_s.det_b = detect_pin_b;
        end

        // read data stands in the enabled cycle after the read strobe and holds while clk_en is low
        next_s.rdata = `CSS_RDATA_RST;
        if (reg_read) begin
            case (rd_sel)
                CSS_SEL_EVENT: next_s.rdata = {28'h000_0000, ev.flags};
                CSS_SEL_STATE: next_s.rdata = state_word;
                // [R14] [R26] force word reads zero
                CSS_SEL_FORCE: next_s.rdata = `CSS_RDATA_RST;
                default: next_s.rdata = `CSS_RDATA_RST;
            endcase
        end
    end

    // ----------------------------------------
    // event sources
    // ----------------------------------------
    assign ev.ce = clk_en;
    assign ev.src = {s.powered, s.det_b, s.det_a, status_pin};
    assign ev.narrow = s.narrow;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            // [R23] reset value, pin bits follow pins
            s <= '0;
            s.power_ctrl_en <= 1'b1;
            // detect mirrors load the pins so the event unit never sees a false change after reset
            s.det_a <= detect_pin_a;
            s.det_b <= detect_pin_b;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = s.rdata;
    // gated so a frozen enable does not stretch the pulse
    assign reinterrogate_req = s.reinterrog & clk_en;
    assign power_ctrl_enable = s.power_ctrl_en;
    assign socket_events = ev.flags;

endmodule : css_socket_regs

// ==== css_cfg.svh ====
// css_cfg.svh: offsets, field positions, reset values of the card socket state block
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CSS_OFF_EVENT 8'h00
`define CSS_OFF_STATE 8'h08
`define CSS_OFF_FORCE 8'h0c

// ----------------------------------------
// state word fields
// ----------------------------------------
`define CSS_ST_ALT_B_SOCK 31
`define CSS_ST_ALT_A_SOCK 30
`define CSS_ST_LOW_SOCK 29
`define CSS_ST_HIGH_SOCK 28
`define CSS_ST_VOLT_HI 13
`define CSS_ST_VOLT_LO 10
`define CSS_ST_INVALID 9
`define CSS_ST_LOSS 8
`define CSS_ST_UNRECOG 7
`define CSS_ST_READY 6
`define CSS_ST_WIDE 5
`define CSS_ST_NARROW 4
`define CSS_ST_POWERED 3
`define CSS_ST_DET_B 2
`define CSS_ST_DET_A 1
`define CSS_ST_STATUS 0

// ----------------------------------------
// force word fields
// ----------------------------------------
`define CSS_FO_REINTERROG 14
`define CSS_FO_VOLT_HI 13
`define CSS_FO_VOLT_LO 10
`define CSS_FO_INVALID 9
`define CSS_FO_LOSS 8
`define CSS_FO_UNRECOG 7
`define CSS_FO_WIDE 5
`define CSS_FO_NARROW 4
`define CSS_FO_EVT_HI 3
`define CSS_FO_EVT_LO 0

// ----------------------------------------
// event word and reset values
// ----------------------------------------
`define CSS_EVT_W 4
`define CSS_STATE_RST 32'h3000_0000
`define CSS_RDATA_RST 32'h0000_0000

`endif

// ==== css_pkg.sv ====
// css_pkg.sv: types of the card socket state block
package css_pkg;

    // register selected by an access
    typedef enum logic [1:0] {
        CSS_SEL_NONE,
        CSS_SEL_EVENT,
        CSS_SEL_STATE,
        CSS_SEL_FORCE
    } css_sel_t;

    // whole state of the core module
    typedef struct packed {
        logic [3:0] card_volt;
        logic invalid_req;
        logic removal_loss;
        logic unrecog;
        logic wide;
        logic narrow;
        logic powered;
        logic det_b;
        logic det_a;
        logic power_ctrl_en;
        logic reinterrog;
        logic [31:0] rdata;
    } css_core_t;

    // whole state of the event unit
    typedef struct packed {
        logic primed;
        logic [3:0] prev;
        logic [3:0] flags;
    } css_evt_t;

endpackage : css_pkg

// ==== css_evt_if.sv ====
// css_evt_if.sv: link between the state core and the event flag unit
`timescale 1ns/1ns
interface css_evt_if;
    logic ce;
    // sources: powered, detect b, detect a, status level
    logic [3:0] src;
    logic [3:0] force_set;
    logic [3:0] clear;
    logic narrow;
    logic [3:0] flags;

    modport core (output ce, output src, output force_set, output clear, output narrow, input flags);
    modport unit (input ce, input src, input force_set, input clear, input narrow, output flags);
endinterface : css_evt_if

// ==== css_event_unit.sv ====
// css_event_unit.sv: sticky socket event flags, set on source change
`timescale 1ns/1ns
`include "css_cfg.svh"
module css_event_unit (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link to core
    css_evt_if.unit ev
);
    import css_pkg::*;

    css_evt_t s;
    css_evt_t next_s;
    logic [3:0] change;

    always_comb begin
        next_s = s;
        change = s.prev ^ ev.src;
        // [R25] status edge rule
        if (!ev.narrow) begin
            change[0] = ev.src[0] & ~s.prev[0];
        end
        // first cycle after reset only learns the levels
        if (!s.primed) begin
            change = 4'h0;
        end
        next_s.primed = 1'b1;
        next_s.prev = ev.src;
        // [R24] set beats clear
        next_s.flags = (s.flags & ~ev.clear) | change | ev.force_set;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
        end else if (ev.ce) begin
            s <= next_s;
        end
    end

    assign ev.flags = s.flags;

endmodule : css_event_unit

// ==== css_chk.sv ====
// css_chk.sv: property checker for the socket register block
`timescale 1ns/1ns
`include "css_cfg.svh"
module css_chk #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // pins and outputs
    input wire logic card_ready_irq_pin,
    input wire logic status_pin,
    input wire logic low_volt_override,
    input wire logic reinterrogate_req,
    input wire logic power_ctrl_enable,
    input wire logic [3:0] socket_events
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic st_rd = clk_en && reg_read && reg_addr == `CSS_OFF_STATE;
    wire logic fo_rd = clk_en && reg_read && reg_addr == `CSS_OFF_FORCE;
    wire logic fo_wr = clk_en && reg_write && reg_addr == `CSS_OFF_FORCE;
    sequence s_fwr;
        fo_wr;
    endsequence
    sequence s_retest;
        s_fwr ##0 reg_wdata[14];
    endsequence
    a_alt_sock_zero: assert property (st_rd |=> reg_rdata[31:30] == 2'h0)
        else $error("alt socket bits set");
    a_low_sock_bit: assert property (st_rd |=> reg_rdata[29] == !$past(low_volt_override))
        else $error("low volt socket bit wrong");
    a_high_sock_one: assert property (st_rd |=> reg_rdata[28])
        else $error("high volt socket bit clear");
    a_resv_zero: assert property (st_rd |=> reg_rdata[27:14] == 14'h0)
        else $error("reserved state bits set");
    a_ready_live: assert property (st_rd |=> reg_rdata[6] == $past(card_ready_irq_pin))
        else $error("ready bit not live");
    a_status_live: assert property (st_rd |=> reg_rdata[0] == $past(status_pin))
        else $error("status bit not live");
    a_force_rd_zero: assert property (fo_rd |=> reg_rdata == 32'h0)
        else $error("force word read not zero");
    a_reinterrog_pulse: assert property (s_retest |=> reinterrogate_req)
        else $error("no reinterrogation request");
    a_power_off: assert property (s_fwr ##0 (reg_wdata[13:10] != 4'h0 && !reg_wdata[14]) |=> !power_ctrl_enable)
        else $error("power control still on");
    a_power_held: assert property (!power_ctrl_enable && !(fo_wr && reg_wdata[14]) |=> !power_ctrl_enable)
        else $error("power control back on");
    a_event_force: assert property (s_fwr |=> (socket_events & $past(reg_wdata[3:0])) == $past(reg_wdata[3:0]))
        else $error("forced event not set");
endmodule : css_chk
bind css_socket_regs css_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

// ==== css_card_model.sv ====
// css_card_model.sv: card in the socket driving its status pins
`timescale 1ns/1ns
module css_card_model (
    // scenario control
    input wire logic present,
    input wire logic ready,
    input wire logic sts,
    // socket pins
    output logic detect_pin_a,
    output logic detect_pin_b,
    output logic card_ready_irq_pin,
    output logic status_pin
);
    // empty socket leaves detect pins to pull-ups
    assign detect_pin_a = !present;
    assign detect_pin_b = !present;
    assign card_ready_irq_pin = present && ready;
    assign status_pin = present && sts;
endmodule : css_card_model

// ==== tb.sv ====
// tb.sv: self-checking bench of the socket register block
`timescale 1ns/1ns
`include "css_cfg.svh"
module tb;
    logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, present = 0, ready = 1, sts = 0;
    logic low_volt_override = 1, interrog_busy = 0, interrog_done = 0, interrog_wide = 1, socket_power_good = 0;
    logic [3:0] interrog_card_volt = 4'ha;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [3:0] socket_events;
    logic detect_pin_a, detect_pin_b, card_ready_irq_pin, status_pin, reinterrogate_req, power_ctrl_enable;
    int err_count = 0, checks_done = 0;
    always #5 clk = ~clk;
    css_card_model i_card (.*);
    css_socket_regs #(.ADDR_W(8)) i_dut (.*, .clk_en(1'b1), .interrog_narrow(!interrog_wide),
        .interrog_unrecog(1'b0), .invalid_request_set(1'b0), .removal_loss_set(1'b0));
    task ck(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : ck
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 0;
        #1;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_read <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 0;
        #1;
        ck(reg_rdata, e);
    endtask : rd
    // detect pin changes need two edges to reach the flags
    task idle;
        repeat (3) @(posedge clk);
        #1;
    endtask : idle
    task t_reset;
        rd(`CSS_OFF_STATE, 32'h1000_0006);
        @(posedge clk) low_volt_override <= 0;
        rd(`CSS_OFF_STATE, 32'h3000_0006);
        rd(`CSS_OFF_FORCE, 32'h0);
        rd(8'h30, 32'h0);
        ck(power_ctrl_enable, 32'h1);
        ck(socket_events, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task t_force;
        wr(`CSS_OFF_FORCE, 32'hffff_bff0);
        ck(power_ctrl_enable, 32'h0);
        rd(`CSS_OFF_STATE, 32'h3000_3fb6);
        wr(`CSS_OFF_FORCE, 32'h0);
        ck(power_ctrl_enable, 32'h0);
        rd(`CSS_OFF_STATE, 32'h3000_0006);
        wr(`CSS_OFF_FORCE, 32'h4000);
        ck(reinterrogate_req, 32'h1);
        ck(power_ctrl_enable, 32'h1);
        $display("force test done");
    endtask : t_force
    task t_events;
        wr(`CSS_OFF_FORCE, 32'hf);
        ck(socket_events, 32'hf);
        rd(`CSS_OFF_STATE, 32'h3000_0006);
        wr(`CSS_OFF_EVENT, 32'h5);
        ck(socket_events, 32'ha);
        wr(`CSS_OFF_EVENT, 32'ha);
        $display("event test done");
    endtask : t_events
    task t_card;
        @(posedge clk) present <= 1;
        idle;
        ck(socket_events, 32'h6);
        rd(`CSS_OFF_STATE, 32'h3000_0040);
        @(posedge clk) interrog_done <= 1;
        socket_power_good <= 1;
        @(posedge clk) interrog_done <= 0;
        idle;
        rd(`CSS_OFF_STATE, 32'h3000_2868);
        ck(socket_events, 32'he);
        @(posedge clk) interrog_busy <= 1;
        present <= 0;
        idle;
        rd(`CSS_OFF_STATE, 32'h3000_2828);
        @(posedge clk) interrog_busy <= 0;
        idle;
        rd(`CSS_OFF_STATE, 32'h3000_282e);
        wr(`CSS_OFF_EVENT, 32'hf);
        ck(socket_events, 32'h0);
        $display("card test done");
    endtask : t_card
    task t_status;
        @(posedge clk) present <= 1;
        sts <= 1;
        idle;
        wr(`CSS_OFF_EVENT, 32'hf);
        rd(`CSS_OFF_STATE, 32'h3000_2869);
        @(posedge clk) sts <= 0;
        idle;
        ck(socket_events, 32'h0);
        wr(`CSS_OFF_FORCE, 32'h10);
        @(posedge clk) sts <= 1;
        idle;
        ck(socket_events, 32'h1);
        wr(`CSS_OFF_EVENT, 32'h1);
        @(posedge clk) sts <= 0;
        idle;
        ck(socket_events, 32'h1);
        $display("status test done");
    endtask : t_status
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1;
        t_reset;
        t_force;
        t_events;
        t_card;
        t_status;
        final_report;
    end
    // tests need under a hundred cycles
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        final_report;
    end
endmodule : tb
